// ---- shared/rcf_pkg.sv ----
`default_nettype none
package rcf_pkg;
	// ************************************************************
	// Redundancy states and roles
	// ************************************************************
	typedef enum logic [2:0] {
		ST_INIT, ST_DISC, ST_AUTH, ST_SYNC, ST_ACTIVE, ST_PASSIVE, ST_STANDALONE, ST_FAULTED
	} rcf_state_t;
	typedef enum logic [1:0] {RL_STANDALONE, RL_ACTIVE, RL_PASSIVE} rcf_role_t;
	// ************************************************************
	// Register map
	// ************************************************************
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_CYCLE_EXT = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;
	localparam int CTRL_REDUND_BIT = 0;
	localparam int CTRL_SWITCH_BIT = 1;
	localparam logic CTRL_REDUND_RST = 1'b1;
	localparam logic [15:0] CYCLE_EXT_RST = 16'h0000;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_ROLE_LSB = 4;
	localparam int STAT_SLOT_BIT = 8;
	localparam int STAT_IO_BIT = 9;
	localparam int STAT_PROTO_BIT = 10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_KHZ = 125000;
	localparam int CYCLE_RED_MS = 10;
	localparam int CYCLE_SA_MS = 3;
	localparam int CYCLE_RED_CYC = CYCLE_RED_MS * CLK_KHZ;
	localparam int CYCLE_SA_CYC = CYCLE_SA_MS * CLK_KHZ;
	localparam int ACK_WAIT_CYC = 1000;
	localparam int CYC_W = 24;
endpackage
`default_nettype wire

// ---- rtl/rcf_cycle_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
module rcf_cycle_timer #(
	parameter int unsigned RED_CYC = rcf_pkg::CYCLE_RED_CYC,
	parameter int unsigned SA_CYC = rcf_pkg::CYCLE_SA_CYC
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic redundant,
	input wire logic [15:0] ext,
	output logic tick
);
	typedef struct packed {
		logic [rcf_pkg::CYC_W-1:0] cnt;
		logic tick;
	} rcf_tmr_t;
	rcf_tmr_t q, d;
	logic [rcf_pkg::CYC_W-1:0] limit;

	// Extension only lengthens the cycle, never below the minimum
	always_comb begin
		limit = (redundant ? rcf_pkg::CYC_W'(RED_CYC) : rcf_pkg::CYC_W'(SA_CYC))
			+ rcf_pkg::CYC_W'(ext) - rcf_pkg::CYC_W'(1);
		d = q;
		d.tick = 1'b0;
		if (q.cnt >= limit) begin
			d.cnt = '0;
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt + rcf_pkg::CYC_W'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			q <= '0;
		else
			q <= d;
	end

	assign tick = q.tick;
endmodule // rcf_cycle_timer
`default_nettype wire

// ---- rtl/rcf_auth_seq.sv ----
`timescale 1ns/10ps
`default_nettype none
module rcf_auth_seq (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic start,
	input wire logic auth_done,
	input wire logic auth_pass,
	output logic auth_req,
	output logic auth_stage,
	output logic done,
	output logic pass
);
	typedef enum logic [1:0] {AS_IDLE, AS_MAKER, AS_CUST} rcf_auth_st_t;
	typedef struct packed {
		rcf_auth_st_t st;
		logic done;
		logic pass;
	} rcf_auth_t;
	rcf_auth_t q, d;

	always_comb begin
		d = q;
		d.done = 1'b0;
		d.pass = 1'b0;
		unique case (q.st)
			AS_IDLE: begin
				if (start)
					d.st = AS_MAKER;
			end
			AS_MAKER: begin
				if (auth_done) begin
					// Customer stage only after maker stage passed
					if (auth_pass) begin
						d.st = AS_CUST;
					end else begin
						d.st = AS_IDLE;
						d.done = 1'b1;
					end
				end
			end
			AS_CUST: begin
				if (auth_done) begin
					d.st = AS_IDLE;
					d.done = 1'b1;
					d.pass = auth_pass;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			q <= '{st: AS_IDLE, done: 1'b0, pass: 1'b0};
		else
			q <= d;
	end

	assign auth_req = (q.st != AS_IDLE);
	assign auth_stage = (q.st == AS_CUST);
	assign done = q.done;
	assign pass = q.pass;
endmodule // rcf_auth_seq
`default_nettype wire

// ---- rtl/rcf_top.sv ----
// Function
// - Standalone after reset until discovery and authentication
// - Initialization entered only by reset
// - Certificate or self-check failure means faulted
// - Discovery succeeds only on partner acknowledgment
// - Discovery exits: authenticate, standalone or faulted
// - Two-stage mutual authentication, maker then customer
// - Both stages pass gives active or passive
// - Equal qualification: slot two becomes active
// - Auth fail: running one standalone, other faulted
// - Auth fail at boot: slot two standalone
// - Active fault hands control to passive
// - Control cycle at least 10ms or 3ms
// - Failover completes within two control cycles
// - Passive disables protocol port, engineering stays
// - Passive never drives field I/O
// - Active drives I/O, else role switch
// - Passive exchanges status with active periodically
// - Passive only after active chosen and synchronized
// - Active sends data to passive each cycle
// - Non-redundant or partner faulted: standalone does control (on a partner fault the survivor stays or becomes active instead)
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module rcf_top #(
	parameter int unsigned RED_CYC = rcf_pkg::CYCLE_RED_CYC,
	parameter int unsigned SA_CYC = rcf_pkg::CYCLE_SA_CYC,
	parameter int unsigned ACK_WAIT = rcf_pkg::ACK_WAIT_CYC
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [rcf_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [rcf_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cert_ok,
	input wire logic startup_self_checks_done,
	input wire logic startup_self_checks_ok,
	input wire logic slot_two,
	input wire logic [3:0] qual_local,
	input wire logic [3:0] qual_partner,
	input wire logic local_fault,
	input wire logic app_ok,
	input wire logic link_up,
	input wire logic ack_rx,
	input wire logic partner_running,
	input wire logic partner_fault,
	input wire logic sync_done,
	input wire logic auth_done,
	input wire logic auth_pass,
	output logic disc_req,
	output logic auth_req,
	output logic auth_stage,
	output logic status_xchg,
	output logic data_xfer,
	output logic field_io_module_en,
	output logic proto_port_en,
	output logic eng_port_en,
	output logic cycle_tick,
	output logic [2:0] redund_state,
	output logic [1:0] role
);
	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		rcf_pkg::rcf_state_t st;
		logic [15:0] cnt;
		logic was_run;
		logic pf;
		logic auth_go;
		logic disc_req;
		logic status_xchg;
		logic data_xfer;
		logic io_en;
		logic proto_en;
		logic redund;
		logic sw;
		logic [15:0] ext;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} rcf_top_t;
	rcf_top_t q, d;

	localparam logic [15:0] ACK_LIM = 16'(ACK_WAIT);
	logic tick;
	logic a_done;
	logic a_pass;
	logic win;
	logic wr;
	logic rd;
	logic [31:0] status_word;

	// ************************************************************
	// Helpers
	// ************************************************************
	rcf_cycle_timer #(
		.RED_CYC(RED_CYC),
		.SA_CYC(SA_CYC)
	) u_timer (
		.core_clk(core_clk),
		.srst(srst),
		.redundant(q.st == rcf_pkg::ST_ACTIVE || q.st == rcf_pkg::ST_PASSIVE),
		.ext(q.ext),
		.tick(tick)
	);

	rcf_auth_seq u_auth (
		.core_clk(core_clk),
		.srst(srst),
		.start(q.auth_go),
		.auth_done(auth_done),
		.auth_pass(auth_pass),
		.auth_req(auth_req),
		.auth_stage(auth_stage),
		.done(a_done),
		.pass(a_pass)
	);

	// Higher qualification wins; ties go to slot two
	assign win = (qual_local > qual_partner) || (qual_local == qual_partner && slot_two);
	assign wr = s_axi_awvalid && s_axi_wvalid && !q.bvalid;
	assign rd = s_axi_arvalid && !q.rvalid;

	always_comb begin
		status_word = '0;
		status_word[rcf_pkg::STAT_STATE_LSB +: 3] = q.st;
		status_word[rcf_pkg::STAT_ROLE_LSB +: 2] = role;
		status_word[rcf_pkg::STAT_SLOT_BIT] = slot_two;
		status_word[rcf_pkg::STAT_IO_BIT] = q.io_en;
		status_word[rcf_pkg::STAT_PROTO_BIT] = q.proto_en;
	end

	// ************************************************************
	// Redundancy state machine
	// ************************************************************
	always_comb begin
		d = q;
		d.auth_go = 1'b0;
		d.disc_req = 1'b0;
		d.status_xchg = 1'b0;
		d.data_xfer = 1'b0;
		// Fault report held until a cycle boundary consumes it
		d.pf = tick ? partner_fault : (q.pf || partner_fault);
		unique case (q.st)
			rcf_pkg::ST_INIT: begin
				if (startup_self_checks_done)
					d.st = (startup_self_checks_ok && cert_ok) ?
						rcf_pkg::ST_DISC : rcf_pkg::ST_FAULTED;
				d.cnt = '0;
			end
			rcf_pkg::ST_DISC: begin
				if (!q.redund || !link_up) begin
					d.st = rcf_pkg::ST_STANDALONE;
				end else if (ack_rx) begin
					d.st = rcf_pkg::ST_AUTH;
					d.auth_go = 1'b1;
				end else if (q.cnt == ACK_LIM) begin
					d.st = rcf_pkg::ST_FAULTED;
				end else begin
					d.disc_req = (q.cnt == '0);
					d.cnt = q.cnt + 16'h0001;
				end
			end
			rcf_pkg::ST_AUTH: begin
				if (a_done) begin
					if (a_pass)
						d.st = win ? rcf_pkg::ST_ACTIVE : rcf_pkg::ST_SYNC;
					else if (q.was_run)
						d.st = rcf_pkg::ST_STANDALONE;
					else if (partner_running)
						d.st = rcf_pkg::ST_FAULTED;
					else
						d.st = slot_two ? rcf_pkg::ST_STANDALONE :
							rcf_pkg::ST_FAULTED;
				end
			end
			rcf_pkg::ST_SYNC: begin
				// Stays out of both running roles until synchronized
				if (!link_up)
					d.st = rcf_pkg::ST_FAULTED;
				else if (sync_done)
					d.st = rcf_pkg::ST_PASSIVE;
			end
			rcf_pkg::ST_ACTIVE: begin
				if (tick) begin
					d.data_xfer = 1'b1;
					d.status_xchg = 1'b1;
					if (!link_up)
						d.st = rcf_pkg::ST_STANDALONE;
					else if (local_fault)
						d.st = rcf_pkg::ST_FAULTED;
					else if ((!app_ok || q.sw) && !q.pf)
						d.st = rcf_pkg::ST_PASSIVE;
				end
			end
			rcf_pkg::ST_PASSIVE: begin
				if (tick) begin
					d.status_xchg = 1'b1;
					if (!link_up || local_fault)
						d.st = rcf_pkg::ST_FAULTED;
					else if (q.pf || q.sw)
						d.st = rcf_pkg::ST_ACTIVE;
				end
			end
			rcf_pkg::ST_STANDALONE: begin
				if (tick) begin
					if (local_fault) begin
						d.st = rcf_pkg::ST_FAULTED;
					end else if (link_up && q.redund) begin
						d.st = rcf_pkg::ST_DISC;
						d.was_run = 1'b1;
						d.cnt = '0;
					end
				end
			end
			rcf_pkg::ST_FAULTED: begin
				d.st = rcf_pkg::ST_FAULTED;
			end
		endcase
		if (tick)
			d.sw = 1'b0;
		// Port gating follows the next state, so it changes with the role
		d.io_en = (d.st == rcf_pkg::ST_ACTIVE || d.st == rcf_pkg::ST_STANDALONE);
		d.proto_en = (d.st != rcf_pkg::ST_PASSIVE);

		// ************************************************************
		// Register bus
		// ************************************************************
		if (q.bvalid && s_axi_bready)
			d.bvalid = 1'b0;
		if (wr) begin
			d.bvalid = 1'b1;
			d.bresp = rcf_pkg::RESP_OKAY;
			unique case (s_axi_awaddr)
				rcf_pkg::OFS_CTRL: begin
					if (s_axi_wstrb[0]) begin
						d.redund = s_axi_wdata[rcf_pkg::CTRL_REDUND_BIT];
						// A new request wins over the cycle-boundary clear
						d.sw = d.sw || s_axi_wdata[rcf_pkg::CTRL_SWITCH_BIT];
					end
				end
				rcf_pkg::OFS_CYCLE_EXT: begin
					if (s_axi_wstrb[0])
						d.ext[7:0] = s_axi_wdata[7:0];
					if (s_axi_wstrb[1])
						d.ext[15:8] = s_axi_wdata[15:8];
				end
				rcf_pkg::OFS_STATUS: begin
					d.bresp = rcf_pkg::RESP_OKAY;
				end
				default: begin
					d.bresp = rcf_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (q.rvalid && s_axi_rready)
			d.rvalid = 1'b0;
		if (rd) begin
			d.rvalid = 1'b1;
			d.rresp = rcf_pkg::RESP_OKAY;
			d.rdata = '0;
			unique case (s_axi_araddr)
				rcf_pkg::OFS_CTRL: begin
					d.rdata[rcf_pkg::CTRL_REDUND_BIT] = q.redund;
					d.rdata[rcf_pkg::CTRL_SWITCH_BIT] = q.sw;
				end
				rcf_pkg::OFS_CYCLE_EXT: begin
					d.rdata[15:0] = q.ext;
				end
				rcf_pkg::OFS_STATUS: begin
					d.rdata = status_word;
				end
				default: begin
					d.rresp = rcf_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	// Reset is the only way into initialization
	always_ff @(posedge core_clk) begin
		if (srst) begin
			q <= '0;
			q.st <= rcf_pkg::ST_INIT;
			q.proto_en <= 1'b1;
			q.redund <= rcf_pkg::CTRL_REDUND_RST;
			q.ext <= rcf_pkg::CYCLE_EXT_RST;
		end else begin
			q <= d;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign s_axi_awready = wr;
	assign s_axi_wready = wr;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = rd;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign disc_req = q.disc_req;
	assign status_xchg = q.status_xchg;
	assign data_xfer = q.data_xfer;
	assign field_io_module_en = q.io_en;
	assign proto_port_en = q.proto_en;
	assign eng_port_en = 1'b1;
	assign cycle_tick = tick;
	assign redund_state = q.st;
	// Every state outside the two running roles reports standalone
	assign role = (q.st == rcf_pkg::ST_ACTIVE) ? rcf_pkg::RL_ACTIVE :
		(q.st == rcf_pkg::ST_PASSIVE) ? rcf_pkg::RL_PASSIVE : rcf_pkg::RL_STANDALONE;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence auth_ok_s;
		a_done && a_pass && q.st == rcf_pkg::ST_AUTH;
	endsequence

	init_entry_a: assert property (q.st != rcf_pkg::ST_INIT |=> q.st != rcf_pkg::ST_INIT)
		else $error("initialization re-entered without reset");
	init_fail_a: assert property (q.st == rcf_pkg::ST_INIT && startup_self_checks_done
		&& !cert_ok |=> q.st == rcf_pkg::ST_FAULTED)
		else $error("bad certificate did not fault");
	disc_nolink_a: assert property (q.st == rcf_pkg::ST_DISC && !link_up
		|=> q.st == rcf_pkg::ST_STANDALONE)
		else $error("missing link did not give standalone");
	ack_wait_a: assert property (q.st == rcf_pkg::ST_DISC && link_up && q.redund && !ack_rx
		&& q.cnt == ACK_LIM |=> q.st == rcf_pkg::ST_FAULTED)
		else $error("acknowledgment timeout did not fault");
	auth_tie_a: assert property (auth_ok_s and (qual_local == qual_partner && slot_two)
		|=> q.st == rcf_pkg::ST_ACTIVE)
		else $error("slot two lost an equal tie");
	boot_fail_a: assert property (q.st == rcf_pkg::ST_AUTH && a_done && !a_pass && !q.was_run
		&& !partner_running && !slot_two |=> q.st == rcf_pkg::ST_FAULTED)
		else $error("slot one survived boot auth failure");
	rerun_fail_a: assert property (q.st == rcf_pkg::ST_AUTH && a_done && !a_pass && q.was_run
		|=> q.st == rcf_pkg::ST_STANDALONE)
		else $error("running controller did not fall back to standalone");
	passive_io_a: assert property (q.st == rcf_pkg::ST_PASSIVE
		|-> !field_io_module_en && !proto_port_en && eng_port_en)
		else $error("passive drives field I/O or protocol port");
	sync_gate_a: assert property ($rose(q.st == rcf_pkg::ST_PASSIVE)
		|-> $past(q.st) != rcf_pkg::ST_SYNC || $past(sync_done))
		else $error("passive before synchronization");
	failover_a: assert property (q.st == rcf_pkg::ST_PASSIVE && tick && q.pf && link_up
		&& !local_fault |=> q.st == rcf_pkg::ST_ACTIVE ##1 field_io_module_en)
		else $error("passive did not take over");
endmodule // rcf_top
`default_nettype wire

// ---- test/rcf_partner.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****
// Partner controller across the interlink
// ****
module rcf_partner #(
	parameter int DLY = 3
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic disc_req,
	input wire logic auth_req,
	input wire logic auth_stage,
	input wire logic ack_en,
	input wire logic pass_maker,
	input wire logic pass_cust,
	output logic ack_rx,
	output logic auth_done,
	output logic auth_pass,
	output logic saw_cust
);
	int dcnt, acnt;
	logic dpend, ans, stg_q;
	always @(posedge core_clk) begin
		ack_rx <= 1'b0;
		auth_done <= 1'b0;
		if (srst) begin
			dpend <= 1'b0;
			ans <= 1'b0;
			acnt <= DLY;
			auth_pass <= 1'b0;
			saw_cust <= 1'b0;
		end else begin
			if (disc_req && ack_en) begin
				dpend <= 1'b1;
				dcnt <= DLY;
			end else if (dpend && dcnt == 0) begin
				ack_rx <= 1'b1;
				dpend <= 1'b0;
			end else begin
				dcnt <= dcnt - 1;
			end
			// Result line is only valid beside done, so it wanders otherwise
			if (!auth_req || (ans && auth_stage !== stg_q)) begin
				ans <= 1'b0;
				acnt <= DLY;
				auth_pass <= ~auth_pass;
			end else if (!ans && acnt == 0) begin
				auth_done <= 1'b1;
				auth_pass <= auth_stage ? pass_cust : pass_maker;
				ans <= 1'b1;
				stg_q <= auth_stage;
				saw_cust <= saw_cust | auth_stage;
			end else begin
				acnt <= acnt - 1;
				auth_pass <= ~auth_pass;
			end
		end
	end
endmodule // rcf_partner
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
	typedef struct packed {
		logic [7:0] ins;
		logic [3:0] ql;
		logic [3:0] qp;
		logic [3:0] st;
		logic [3:0] fl;
	} rcf_row_t;
	localparam int RED = 40;
	localparam int SA = 12;
	// ins: cert, checks, link, ack, maker, customer, slot two, partner running
	// fl: io, proto, customer stage seen
	localparam rcf_row_t ROWS [11] = '{24'h7C5572, 24'hBC5572, 24'hDC5566, 24'hEC5572,
		24'hFC5347, 24'hFC3551, 24'hFE5547, 24'hFC5551, 24'hF65566, 24'hF45572, 24'hFB5573};
	logic core_clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, qual_local, qual_partner;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, role, rr;
	logic cert_ok, startup_self_checks_done, startup_self_checks_ok, slot_two, local_fault;
	logic app_ok, link_up, ack_rx, partner_running, partner_fault, sync_done, auth_done;
	logic auth_pass, disc_req, auth_req, auth_stage, status_xchg, data_xfer;
	logic field_io_module_en, proto_port_en, eng_port_en, cycle_tick;
	logic ack_en, pass_maker, pass_cust, saw_cust;
	logic [2:0] redund_state, st_q;
	int errors, n_checks, n, dx, sx;
	rcf_top #(.RED_CYC(RED), .SA_CYC(SA), .ACK_WAIT(8)) dut (
		.core_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .cert_ok, .startup_self_checks_done,
		.startup_self_checks_ok, .slot_two, .qual_local, .qual_partner, .local_fault, .app_ok,
		.link_up, .ack_rx, .partner_running, .partner_fault, .sync_done, .auth_done,
		.auth_pass, .disc_req, .auth_req, .auth_stage, .status_xchg, .data_xfer,
		.field_io_module_en, .proto_port_en, .eng_port_en, .cycle_tick, .redund_state, .role
	);
	rcf_partner #(.DLY(3)) partner (
		.core_clk, .srst, .disc_req, .auth_req, .auth_stage, .ack_en, .pass_maker,
		.pass_cust, .ack_rx, .auth_done, .auth_pass, .saw_cust
	);
	always #4 core_clk = ~core_clk;
	// ****
	// Shared tasks
	// ****
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		chk("bresp", s_axi_bresp, er);
		s_axi_bready <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic axr(input logic [3:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic boot(input rcf_row_t r);
		@(posedge core_clk);
		srst <= 1'b1;
		{cert_ok, startup_self_checks_ok, link_up, ack_en, pass_maker, pass_cust, slot_two,
			partner_running} <= r.ins;
		qual_local <= r.ql;
		qual_partner <= r.qp;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
	endtask
	task automatic wait_st(input logic [2:0] s, input int lim);
		n = 0;
		while (n < lim && redund_state !== s) begin
			@(posedge core_clk);
			n++;
		end
	endtask
	// Counts one full cycle between two ticks, with the pulses seen inside it
	task automatic period;
		for (int i = 0; i < 200 && cycle_tick !== 1'b1; i++) @(posedge core_clk);
		n = 0;
		dx = 0;
		sx = 0;
		do begin
			@(posedge core_clk);
			n++;
			dx += data_xfer;
			sx += status_xchg;
		end while (cycle_tick !== 1'b1 && n < 200);
	endtask
	always @(posedge core_clk) begin
		if (!srst) begin
			if (redund_state < 3'h4) chk("early_role", role, 2'h0);
			if (role === 2'h2) chk("passive_ports", {field_io_module_en, proto_port_en, eng_port_en}, 3'h1);
			if (redund_state === 3'h0 && st_q !== 3'h0) chk("reinit", 1'b1, 1'b0);
		end
		st_q <= redund_state;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		errors++;
		give_verdict;
	end
	// ****
	// Main sequence
	// ****
	initial begin
		core_clk = 1'b0;
		srst <= 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} <= {8'h00, 4'hF, 32'h0};
		{cert_ok, startup_self_checks_done, startup_self_checks_ok, slot_two} <= 4'hF;
		{local_fault, app_ok, link_up, partner_running, partner_fault, sync_done} <= 6'h11;
		{ack_en, pass_maker, pass_cust, qual_local, qual_partner} <= 11'h700;
		errors = 0;
		n_checks = 0;
		repeat (16) @(posedge core_clk);
		srst <= 1'b0;
		axr(rcf_pkg::OFS_CTRL);
		chk("ctrl", rd, 32'h1);
		axr(rcf_pkg::OFS_CYCLE_EXT);
		chk("cycle_ext", rd, 32'h0);
		axr(4'hC);
		chk("unmapped_resp", rr, rcf_pkg::RESP_SLVERR);
		chk("unmapped_data", rd, 32'h0);
		axw(4'hC, 32'h5, rcf_pkg::RESP_SLVERR);
		axw(rcf_pkg::OFS_STATUS, 32'h0, rcf_pkg::RESP_OKAY);
		axr(rcf_pkg::OFS_STATUS);
		chk("slot_bit", rd[8], 1'b1);
		$display("registers test done");
		foreach (ROWS[i]) begin
			boot(ROWS[i]);
			wait_st(ROWS[i].st[2:0], 300);
			chk("state", redund_state, ROWS[i].st);
			chk("io_en", field_io_module_en, ROWS[i].fl[2]);
			chk("proto_en", proto_port_en, ROWS[i].fl[1]);
			chk("cust_stage", saw_cust, ROWS[i].fl[0]);
		end
		$display("boot table test done");
		sync_done <= 1'b0;
		boot(ROWS[5]);
		wait_st(3'h5, 100);
		chk("unsynced", redund_state, 3'h3);
		sync_done <= 1'b1;
		wait_st(3'h5, 20);
		chk("synced", redund_state, 3'h5);
		period;
		chk("passive_cycle", n, RED);
		chk("passive_xfer", dx, 32'h0);
		chk("passive_status", sx, 32'h1);
		partner_fault <= 1'b1;
		@(posedge core_clk);
		partner_fault <= 1'b0;
		wait_st(3'h4, 3 * RED);
		chk("failover", redund_state, 3'h4);
		chk("failover_time", n <= 2 * RED, 1'b1);
		period;
		chk("active_cycle", n, RED);
		chk("active_xfer", dx, 32'h1);
		chk("active_status", sx, 32'h1);
		app_ok <= 1'b0;
		wait_st(3'h5, 2 * RED);
		chk("app_lost", redund_state, 3'h5);
		app_ok <= 1'b1;
		axw(rcf_pkg::OFS_CTRL, 32'h3, rcf_pkg::RESP_OKAY);
		wait_st(3'h4, 2 * RED);
		chk("switch_req", redund_state, 3'h4);
		link_up <= 1'b0;
		wait_st(3'h6, 2 * RED);
		chk("alone", {redund_state, field_io_module_en}, {3'h6, 1'b1});
		period;
		chk("alone_cycle", n, SA);
		axw(rcf_pkg::OFS_CYCLE_EXT, 32'h4, rcf_pkg::RESP_OKAY);
		period;
		period;
		chk("ext_cycle", n, SA + 4);
		pass_maker <= 1'b0;
		link_up <= 1'b1;
		wait_st(3'h1, 40);
		chk("rediscover", redund_state, 3'h1);
		wait_st(3'h6, 100);
		chk("rerun_fail", redund_state, 3'h6);
		$display("role test done");
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk("reset", {redund_state, role, field_io_module_en, proto_port_en, s_axi_bvalid,
			s_axi_rvalid}, 9'h004);
		srst <= 1'b0;
		$display("reset test done");
		give_verdict;
	end
endmodule // testbench
`default_nettype wire
